// ---- bench/bldcdc_hall_model.sv ----
// hall sensor model: six-step modified gray sequence
`timescale 1ns/1ns
module bldcdc_hall_model (
    // clock and step request
    input  wire logic                  clk,
    input  wire logic                  step,
    // sensor levels
    output bldcdc_pkg::bldcdc_hall_type hall
);
    logic [2:0] pos_reg = 3'h0;
    logic [2:0] seq_reg [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
    // one input changes per step, so no transient state reaches the decoder
    always_ff @(posedge clk) begin
        if (step) begin
            pos_reg <= (pos_reg == 3'h5) ? 3'h0 : pos_reg + 3'h1;
        end
    end
    assign hall = seq_reg[pos_reg];
endmodule

// ---- bench/bldcdc_properties.sv ----
// checker: port timing relations of the bldc commutation block
`timescale 1ns/1ns
module bldcdc_properties (
    input wire logic                         clk,
    input wire logic                         resetn,
    input wire bldcdc_pkg::bldcdc_hall_type  hall,
    input wire logic                         dir_cmd,
    input wire logic                         speed_above,
    input wire logic                         pwm_trip,
    input wire bldcdc_pkg::bldcdc_drive_type drive_out,
    input wire logic                         tach_pulse_out,
    input wire logic                         osc_tick,
    input wire logic                         drive_inhibit
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [9:0] cnt_reg;
    // mirror of the oscillator count, cleared like the real one
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= 10'h000;
        end else begin
            cnt_reg <= osc_tick ? 10'h000 : cnt_reg + 10'h001;
        end
    end
    a_tick_period: assert property (osc_tick == (cnt_reg == bldcdc_pkg::OSC_LAST))
        else $error("tick period");
    a_inhibit_blank: assert property (drive_inhibit |=> drive_out == 6'h00)
        else $error("drive while inhibited");
    a_change_inhibit: assert property ($changed(dir_cmd) && !$past(speed_above) |-> drive_inhibit)
        else $error("no inhibit on change");
    a_fast_hold: assert property (speed_above && !osc_tick && drive_inhibit
        |=> drive_inhibit || $changed(dir_cmd)) else $error("latch not held");
    a_toggle_tach: assert property ($changed(dir_cmd) |=> tach_pulse_out)
        else $error("no tach pulse");
    a_trip_chop: assert property (pwm_trip |-> ##2 drive_out == 6'h00)
        else $error("no chop");
    a_start_drive: assert property ((osc_tick && !pwm_trip) ##1
        (!drive_inhibit && hall != 3'h0 && hall != 3'h7) |=> drive_out != 6'h00)
        else $error("no drive after start");
    a_decode_safe: assert property ($onehot0(drive_out.high_side_drive)
        && $onehot0(drive_out.low_side_drive)
        && (drive_out.high_side_drive & drive_out.low_side_drive) == 3'h0)
        else $error("unsafe drive");
    cover property ($changed(dir_cmd) && speed_above);
    cover property (pwm_trip && osc_tick);
    cover property ($fell(drive_inhibit));
endmodule
bind bldcdc_top bldcdc_properties bldcdc_properties_i (.clk, .resetn, .hall, .dir_cmd,
    .speed_above, .pwm_trip, .drive_out, .tach_pulse_out, .osc_tick, .drive_inhibit);

// ---- bench/tb_bldcdc_top.sv ----
// testbench: decode, reversal, tach and chop of the bldc block
`timescale 1ns/1ns
module tb_bldcdc_top;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic dir_cmd = 1'b0;
    logic speed_above = 1'b0;
    logic pwm_trip = 1'b0;
    logic step = 1'b0;
    bldcdc_pkg::bldcdc_hall_type  hall;
    bldcdc_pkg::bldcdc_drive_type drive_out;
    logic tach_pulse_out;
    logic osc_tick;
    logic drive_inhibit;
    int   n_mismatch = 0;
    int   tests_run = 0;
    always #20 clk = ~clk;
    bldcdc_hall_model bldcdc_hall_model_i (.clk, .step, .hall);
    bldcdc_top bldcdc_top_i (.clk, .resetn, .hall, .dir_cmd, .speed_above, .pwm_trip,
        .drive_out, .tach_pulse_out, .osc_tick, .drive_inhibit);
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    // reverse swaps high and low sides
    function automatic logic [5:0] exp_drive(input logic [2:0] h, input logic d);
        logic [5:0] v;
        case (h)
            3'h1: v = 6'h0a;
            3'h3: v = 6'h0c;
            3'h2: v = 6'h14;
            3'h6: v = 6'h11;
            3'h4: v = 6'h21;
            3'h5: v = 6'h22;
            default: v = 6'h00;
        endcase
        return d ? {v[2:0], v[5:3]} : v;
    endfunction
    task automatic sweep(input logic d);
        for (int i = 0; i < 6; i++) begin
            step = 1'b1;
            cyc(1);
            step = 1'b0;
            cyc(2);
            chk(drive_out === exp_drive(hall, d), "decode");
        end
        $display("sweep dir %0d done", d);
    endtask
    task automatic t_slow;
        int n;
        n = 0;
        dir_cmd = 1'b1;
        cyc(2);
        chk(tach_pulse_out === 1'b1, "tach");
        while (drive_inhibit === 1'b1 && n < 2000) begin
            chk(drive_out === 6'h00, "blank");
            cyc(1);
            n++;
        end
        chk(n >= 620 && n <= 1252, "delay");
        sweep(1'b1);
    endtask
    // tach left to expire first, so a fresh pulse is seen
    task automatic t_fast;
        speed_above = 1'b1;
        cyc(5600);
        chk(tach_pulse_out === 1'b0, "tach end");
        dir_cmd = 1'b0;
        cyc(2);
        chk(tach_pulse_out === 1'b1, "tach fast");
        cyc(1400);
        chk(drive_inhibit === 1'b1 && drive_out === 6'h00, "held");
        speed_above = 1'b0;
        cyc(1300);
        chk(drive_inhibit === 1'b0, "released");
        sweep(1'b0);
    endtask
    // trip raised on the tick itself: trip must win
    task automatic t_chop;
        for (int i = 0; i < 700 && osc_tick !== 1'b1; i++) cyc(1);
        pwm_trip = 1'b1;
        // looked at two edges after the tick: a tick that won would still show a drive here
        cyc(2);
        chk(drive_out === 6'h00, "chop");
        pwm_trip = 1'b0;
        cyc(300);
        chk(drive_out === 6'h00, "chop held");
        cyc(330);
        chk(drive_out === exp_drive(hall, 1'b0), "restart");
        $display("chop done");
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        cyc(16);
        resetn = 1'b1;
        cyc(630);
        sweep(1'b0);
        t_slow;
        t_fast;
        t_chop;
        end_of_test;
    end
    initial begin
        cyc(30000);
        n_mismatch++;
        end_of_test;
    end
endmodule

// ---- src/bldcdc_decoder.sv ----
// module: hall position decoder to six driver commands
`timescale 1ns/1ns
module bldcdc_decoder (
    // position and direction
    input  wire bldcdc_pkg::bldcdc_hall_type  hall,
    input  wire logic                         dir,
    // decoded drive
    output bldcdc_pkg::bldcdc_drive_type      drive
);

    // ****************************************
    // six step table
    // ****************************************
    logic [2:0] code;
    logic [2:0] hs;
    logic [2:0] ls;

    assign code = {hall.hall_a, hall.hall_b, hall.hall_c};

    always_comb begin
        hs = 3'h0;
        ls = 3'h0;
        unique case (code)
            3'h1: begin
                hs = 3'h1;
                ls = 3'h2;
            end
            3'h3: begin
                hs = 3'h1;
                ls = 3'h4;
            end
            3'h2: begin
                hs = 3'h2;
                ls = 3'h4;
            end
            3'h6: begin
                hs = 3'h2;
                ls = 3'h1;
            end
            3'h4: begin
                hs = 3'h4;
                ls = 3'h1;
            end
            3'h5: begin
                hs = 3'h4;
                ls = 3'h2;
            end
            // all-equal codes are sensor faults: drive nothing
            default: begin
                hs = 3'h0;
                ls = 3'h0;
            end
        endcase
        // reverse rotation swaps the high and low phase sets
        if (dir) begin
            drive.high_side_drive = ls;
            drive.low_side_drive  = hs;
        end else begin
            drive.high_side_drive = hs;
            drive.low_side_drive  = ls;
        end
    end

endmodule

// ---- src/bldcdc_pkg.sv ----
// package: constants and carriers for the bldc direction and commutation block
package bldcdc_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_FREQ_HZ = 25000000;
    localparam int OSC_FREQ_HZ = 40000;
    // oscillator period in clock cycles, rounded down
    localparam int OSC_PERIOD_CYCLES = CLK_FREQ_HZ / OSC_FREQ_HZ;
    localparam int OSC_CNT_W = 10;
    localparam logic [OSC_CNT_W-1:0] OSC_LAST = 10'(OSC_PERIOD_CYCLES - 1);
    localparam logic [OSC_CNT_W-1:0] OSC_RESET_CNT = 10'h000;

    // tach pulse on time, 220 us
    localparam int TACH_ON_US = 220;
    localparam int TACH_ON_CYCLES = (CLK_FREQ_HZ / 1000000) * TACH_ON_US;
    localparam int TACH_CNT_W = 13;
    localparam logic [TACH_CNT_W-1:0] TACH_LOAD = 13'(TACH_ON_CYCLES);

    // ****************************************
    // reset values
    // ****************************************
    localparam logic DIR_RESET = 1'b0;
    localparam logic PWM_LATCH_RESET = 1'b0;
    localparam logic [1:0] SHIFT_RESET = 2'h0;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic hall_a;
        logic hall_b;
        logic hall_c;
    } bldcdc_hall_type;

    typedef struct packed {
        logic [2:0] high_side_drive;
        logic [2:0] low_side_drive;
    } bldcdc_drive_type;

endpackage

// ---- src/bldcdc_top.sv ----
// module: commutation, safe reversal, tach and pwm chop for a bldc controller
`timescale 1ns/1ns
module bldcdc_top (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         resetn,
    // position sensors and commands
    input  wire bldcdc_pkg::bldcdc_hall_type  hall,
    input  wire logic                         dir_cmd,
    input  wire logic                         speed_above,
    input  wire logic                         pwm_trip,
    // outputs
    output bldcdc_pkg::bldcdc_drive_type      drive_out,
    output logic                              tach_pulse_out,
    output logic                              osc_tick,
    output logic                              drive_inhibit
);

    // ****************************************
    // pwm oscillator
    // ****************************************
    logic [bldcdc_pkg::OSC_CNT_W-1:0] osc_cnt_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            osc_cnt_reg <= bldcdc_pkg::OSC_RESET_CNT;
        end else if (osc_cnt_reg == bldcdc_pkg::OSC_LAST) begin
            osc_cnt_reg <= bldcdc_pkg::OSC_RESET_CNT;
        end else begin
            osc_cnt_reg <= osc_cnt_reg + 10'h001;
        end
    end

    assign osc_tick = (osc_cnt_reg == bldcdc_pkg::OSC_LAST);

    // ****************************************
    // direction latch
    // ****************************************
    // modelled as a register that follows every clock while slow; one clock of
    // lag stands in for the transparent path and keeps the mismatch visible
    logic dir_latch_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dir_latch_reg <= bldcdc_pkg::DIR_RESET;
        end else if (!speed_above) begin
            dir_latch_reg <= dir_cmd;
        end
        // fast rotation: latch holds, no change enters the shift path
    end

    // ****************************************
    // direction shift register
    // ****************************************
    logic [1:0] dir_shift_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dir_shift_reg <= bldcdc_pkg::SHIFT_RESET;
        end else if (osc_tick) begin
            dir_shift_reg <= {dir_shift_reg[0], dir_latch_reg};
        end
    end

    // ****************************************
    // mismatch inhibit
    // ****************************************
    // drives stay off while a reversal is pending so the motor can coast
    assign drive_inhibit = (dir_cmd != dir_latch_reg)
                         | (dir_latch_reg != dir_shift_reg[1]);

    // ****************************************
    // tachometer pulse on direction toggle
    // ****************************************
    logic                              dir_cmd_prev_reg;
    logic [bldcdc_pkg::TACH_CNT_W-1:0] tach_cnt_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dir_cmd_prev_reg <= bldcdc_pkg::DIR_RESET;
        end else begin
            dir_cmd_prev_reg <= dir_cmd;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tach_cnt_reg <= '0;
        end else if (dir_cmd != dir_cmd_prev_reg) begin
            tach_cnt_reg <= bldcdc_pkg::TACH_LOAD;
        end else if (tach_cnt_reg != '0) begin
            tach_cnt_reg <= tach_cnt_reg - 13'h0001;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tach_pulse_out <= 1'b0;
        end else begin
            tach_pulse_out <= (dir_cmd != dir_cmd_prev_reg) || (tach_cnt_reg > 13'h0001);
        end
    end

    // ****************************************
    // pwm latch
    // ****************************************
    logic pwm_latch_reg;

    // a trip in the same cycle as the period start wins: current limit first
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pwm_latch_reg <= bldcdc_pkg::PWM_LATCH_RESET;
        end else if (pwm_trip) begin
            pwm_latch_reg <= 1'b0;
        end else if (osc_tick) begin
            pwm_latch_reg <= 1'b1;
        end
    end

    // ****************************************
    // decode and output gating
    // ****************************************
    bldcdc_pkg::bldcdc_drive_type decoded;
    logic                         gate_on;

    bldcdc_decoder u_decoder (
        .hall  (hall),
        .dir   (dir_shift_reg[1]),
        .drive (decoded)
    );

    assign gate_on = pwm_latch_reg & ~drive_inhibit;

    // registered outputs avoid decoder glitches reaching the power stage
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            drive_out <= '0;
        end else if (gate_on) begin
            drive_out <= decoded;
        end else begin
            drive_out <= '0;
        end
    end

endmodule
